//--- pin_config_pkg.sv
// Constants, register map and carrier types for the port pin configuration
// block. Assumes an 8-pin port and a 32-bit Avalon-MM register bus.
package pin_config_pkg;

    localparam int pin_count = 8;

    // Printed offsets are not word aligned, so they are register indices
    localparam logic [11:0] index_reg_index = 12'hFD0;
    localparam logic [11:0] window_reg_index = 12'hFD1;
    localparam logic [11:0] stop_state_reg_index = 12'hFD2;
    localparam logic [11:0] pin_state_reg_index = 12'hFD3;
    localparam int addr_width = 14;

    // Subregister selector values
    localparam logic [7:0] sel_open_drain = 8'h03;
    localparam logic [7:0] sel_strong_drive = 8'h04;
    localparam logic [7:0] sel_wake_source = 8'h05;
    localparam logic [7:0] sel_weak_pullup = 8'h06;

    localparam logic [7:0] reset_value = 8'h00;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    typedef struct packed {
        logic [addr_width-1:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } bus_request_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bus_answer_type;

    // Per-pin settings delivered to the pad ring
    typedef struct packed {
        logic [pin_count-1:0] drain_enable;
        logic [pin_count-1:0] strong_drive;
        logic [pin_count-1:0] pullup_enable;
    } pad_control_type;

    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_answer = 2'b01
    } bus_state_type;

endpackage

//--- pin_sync.sv
// Two-flop synchroniser for one pad input.
// Assumes the pad level is asynchronous to clock.
module pin_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Data
    input wire logic level_in,
    output logic level_out
);
    logic first_stage;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_stage <= 1'b0;
            level_out <= 1'b0;
        end else begin
            first_stage <= level_in;
            level_out <= first_stage;
        end
    end
endmodule

//--- port_pin_config_subregs.sv
// Port pin configuration registers behind an indexed subregister window.
// Assumes an Avalon-MM master on clock and pad inputs from the pins.
module port_pin_config_subregs
    import pin_config_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [pin_config_pkg::addr_width-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Alternate function drain override per pin, from the same clock
    input wire logic [pin_config_pkg::pin_count-1:0] alt_drain_disable,
    // Pads
    input wire logic [pin_config_pkg::pin_count-1:0] pin_level,
    output pin_config_pkg::pad_control_type pad_control,
    // Power state
    input wire logic stop_state,
    output logic stop_recovery
);
    import pin_config_pkg::*;

    bus_request_type request;
    bus_state_type bus_state;
    logic [7:0] port_a_subreg_index;
    logic [7:0] open_drain_bits;
    logic [7:0] strong_drive_bits;
    logic [7:0] wake_source_bits;
    logic [7:0] weak_pullup_bits;
    logic [pin_count-1:0] pin_synced;
    logic [pin_count-1:0] pin_last;
    logic [7:0] window_value;
    logic [31:0] next_readdata;
    logic take;
    logic low_lane;
    logic hit_index;
    logic hit_window;

    assign request = '{address, read, write, byteenable, writedata};

    // Word address is the register index
    assign hit_index = request.address[addr_width-1:2] == index_reg_index;
    assign hit_window = request.address[addr_width-1:2] == window_reg_index;
    assign low_lane = request.byteenable[0];

    // One wait state: accept on the idle cycle, answer on the next
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_state <= bus_idle;
        end else begin
            unique case (bus_state)
                bus_idle: begin
                    if (request.read || request.write) begin
                        bus_state <= bus_answer;
                    end
                end
                bus_answer: begin
                    bus_state <= bus_idle;
                end
            endcase
        end
    end

    assign waitrequest = !(bus_state == bus_answer);
    assign take = bus_state == bus_answer;

    // Subregister currently behind the window
    always_comb begin
        unique case (port_a_subreg_index)
            sel_open_drain: window_value = open_drain_bits;
            sel_strong_drive: window_value = strong_drive_bits;
            sel_wake_source: window_value = wake_source_bits;
            sel_weak_pullup: window_value = weak_pullup_bits;
            default: window_value = reset_value;
        endcase
    end

    always_comb begin
        next_readdata = unmapped_read;
        if (hit_index) begin
            next_readdata[7:0] = port_a_subreg_index;
        end else if (hit_window) begin
            next_readdata[7:0] = window_value;
        end else if (request.address[addr_width-1:2] == stop_state_reg_index)
        begin
            next_readdata[0] = stop_recovery;
        end else if (request.address[addr_width-1:2] == pin_state_reg_index)
        begin
            next_readdata[pin_count-1:0] = pin_synced;
        end
    end

    // Data captured while waiting, so it stands at the answering edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= unmapped_read;
        end else if (bus_state == bus_idle && request.read) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port_a_subreg_index <= reset_value;
        end else if (take && request.write && hit_index && low_lane) begin
            port_a_subreg_index <= request.writedata[7:0];
        end
    end

    // Unknown selectors leave every subregister untouched
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            open_drain_bits <= reset_value;
            strong_drive_bits <= reset_value;
            wake_source_bits <= reset_value;
            weak_pullup_bits <= reset_value;
        end else if (take && request.write && hit_window && low_lane) begin
            unique case (port_a_subreg_index)
                sel_open_drain: open_drain_bits <= request.writedata[7:0];
                sel_strong_drive: strong_drive_bits <= request.writedata[7:0];
                sel_wake_source: wake_source_bits <= request.writedata[7:0];
                sel_weak_pullup: weak_pullup_bits <= request.writedata[7:0];
                default: ;
            endcase
        end
    end

    // Pad control is combinational from the bits so alternate functions
    // see the same setting without a pipeline stage
    assign pad_control.drain_enable = ~open_drain_bits
        & ~alt_drain_disable;
    assign pad_control.strong_drive = strong_drive_bits;
    assign pad_control.pullup_enable = weak_pullup_bits;

    genvar pin;
    generate
        for (pin = 0; pin < pin_count; pin++) begin : sync_pins
            pin_sync sync (
                .clock(clock),
                .reset_n(reset_n),
                .level_in(pin_level[pin]),
                .level_out(pin_synced[pin])
            );
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_last <= '0;
        end else begin
            pin_last <= pin_synced;
        end
    end

    // Recovery is a one-cycle pulse on an enabled edge during stop
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stop_recovery <= 1'b0;
        end else begin
            stop_recovery <= stop_state
                && |((pin_synced ^ pin_last) & wake_source_bits);
        end
    end

    property p_open_drain;
        @(posedge clock) disable iff (!reset_n)
        open_drain_bits[0] |-> !pad_control.drain_enable[0];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("drain enabled with open-drain bit set");

    property p_drain_on;
        @(posedge clock) disable iff (!reset_n)
        (!open_drain_bits[1] && !alt_drain_disable[1])
            |-> pad_control.drain_enable[1];
    endproperty
    a_drain_on: assert property (p_drain_on)
        else $error("drain disabled without cause");

    property p_wake;
        @(posedge clock) disable iff (!reset_n)
        (stop_state && wake_source_bits[2] && pin_synced[2] != pin_last[2])
            |=> stop_recovery;
    endproperty
    a_wake: assert property (p_wake)
        else $error("enabled transition did not start recovery");

    property p_no_wake;
        @(posedge clock) disable iff (!reset_n)
        (wake_source_bits == 8'h00 || !stop_state) |=> !stop_recovery;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("recovery without an enabled source");

    property p_write_od;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_window && low_lane
            && port_a_subreg_index == sel_open_drain)
            |=> open_drain_bits == $past(request.writedata[7:0]);
    endproperty
    a_write_od: assert property (p_write_od)
        else $error("open-drain write lost");

    property p_write_hd;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_window && low_lane
            && port_a_subreg_index == sel_strong_drive)
            |=> pad_control.strong_drive == $past(request.writedata[7:0]);
    endproperty
    a_write_hd: assert property (p_write_hd)
        else $error("strong drive write lost");

    property p_write_pu;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_window && low_lane
            && port_a_subreg_index == sel_weak_pullup)
            |=> pad_control.pullup_enable == $past(request.writedata[7:0]);
    endproperty
    a_write_pu: assert property (p_write_pu)
        else $error("pull-up write lost");

    property p_only_selected;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && port_a_subreg_index != sel_wake_source)
            |=> $stable(wake_source_bits);
    endproperty
    a_only_selected: assert property (p_only_selected)
        else $error("unselected subregister changed");

    property p_read_window;
        @(posedge clock) disable iff (!reset_n)
        (bus_state == bus_idle && request.read && hit_window
            && port_a_subreg_index == sel_wake_source)
            |=> readdata[7:0] == $past(wake_source_bits) && !waitrequest;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("window read returned wrong subregister");

    property p_write_ws;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_window && low_lane
            && port_a_subreg_index == sel_wake_source)
            |=> wake_source_bits == $past(request.writedata[7:0]);
    endproperty
    a_write_ws: assert property (p_write_ws)
        else $error("wake source write lost");

    property p_index_write;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_index && low_lane)
            |=> port_a_subreg_index == $past(request.writedata[7:0]);
    endproperty
    a_index_write: assert property (p_index_write)
        else $error("selector write lost");

    // Selectors outside the mapped range must not reach any subregister
    property p_bad_sel;
        @(posedge clock) disable iff (!reset_n)
        (take && request.write && hit_window
            && (port_a_subreg_index < sel_open_drain
            || port_a_subreg_index > sel_weak_pullup))
            |=> $stable(open_drain_bits) && $stable(strong_drive_bits)
            && $stable(wake_source_bits) && $stable(weak_pullup_bits);
    endproperty
    a_bad_sel: assert property (p_bad_sel)
        else $error("write through unknown selector stored");

    property p_reset_clear;
        @(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> open_drain_bits == reset_value
            && strong_drive_bits == reset_value
            && wake_source_bits == reset_value
            && weak_pullup_bits == reset_value;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("subregister not cleared by reset");

    property p_masked_wake;
        @(posedge clock) disable iff (!reset_n)
        (stop_state
            && ((pin_synced ^ pin_last) & wake_source_bits) == 8'h00)
            |=> !stop_recovery;
    endproperty
    a_masked_wake: assert property (p_masked_wake)
        else $error("recovery from a masked pin");

    property p_drain_all;
        @(posedge clock) disable iff (!reset_n)
        (open_drain_bits & pad_control.drain_enable) == 8'h00;
    endproperty
    a_drain_all: assert property (p_drain_all)
        else $error("open-drain pin still drives");

endmodule

//--- port_pin_config_subregs_test.sv
// Self-checking bench for the port pin configuration block.
// Assumes the one-wait-cycle Avalon slave and 2-flop pin sync of the design.
module port_pin_config_subregs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_config_pkg::*;

    localparam logic [13:0] a_index = 14'h3F40;
    localparam logic [13:0] a_window = 14'h3F44;
    localparam logic [13:0] a_unmapped = 14'h0100;

    logic clock, reset_n, read, write, stop_state, stop_recovery, waitrequest;
    logic [13:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, rdata;
    logic [7:0] alt_drain_disable, pin_level;
    pad_control_type pad_control;
    int failures, n_checks, cnt;

    port_pin_config_subregs u_port_pin_config_subregs (
        .clock(clock), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .alt_drain_disable(alt_drain_disable), .pin_level(pin_level),
        .pad_control(pad_control), .stop_state(stop_state),
        .stop_recovery(stop_recovery)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low at a rising edge;
    // only the watchdog ends a wait that never gets its answer
    task automatic bus(input logic wr, input logic [13:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, d};
        byteenable <= be;
        // Read right at the edge, before the design's updates land
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic sub_write(input logic [7:0] sel, input logic [7:0] d);
        bus(1'b1, a_index, sel, 4'hF);
        bus(1'b1, a_window, d, 4'hF);
    endtask

    task automatic sub_read(input logic [7:0] sel);
        bus(1'b1, a_index, sel, 4'hF);
        bus(1'b0, a_window, 8'h00, 4'hF);
    endtask

    task automatic test_reset();
        bus(1'b0, a_index, 8'h00, 4'hF);
        check("index reset", rdata, 32'h00000000);
        for (int s = 3; s <= 6; s++) begin
            sub_read(8'(s));
            check("subreg reset", rdata, 32'h00000000);
        end
        check("pads reset", 32'(pad_control), 32'h00FF0000);
    endtask

    task automatic test_select();
        logic [7:0] vals [4];
        vals = '{8'h5A, 8'h3C, 8'h01, 8'hC3};
        for (int s = 0; s < 4; s++)
            sub_write(8'(s + 3), vals[s]);
        sub_write(8'h07, 8'hA5);
        // Byte lane 0 disabled: the write must store nothing
        bus(1'b1, a_window, 8'hFF, 4'h0);
        sub_read(8'h03);
        check("open drain", rdata, 32'h0000005A);
        sub_read(8'h04);
        check("strong drive", rdata, 32'h0000003C);
        sub_read(8'h05);
        check("wake source", rdata, 32'h00000001);
        sub_read(8'h06);
        check("weak pullup", rdata, 32'h000000C3);
        sub_read(8'h07);
        check("unselected window", rdata, 32'h00000000);
        bus(1'b0, a_index, 8'h00, 4'hF);
        check("index readback", rdata, 32'h00000007);
        bus(1'b0, a_unmapped, 8'h00, 4'hF);
        check("unmapped read", rdata, 32'h00000000);
    endtask

    task automatic test_pads();
        check("drain", 32'(pad_control.drain_enable), 32'h000000A5);
        check("strong", 32'(pad_control.strong_drive), 32'h0000003C);
        check("pullup", 32'(pad_control.pullup_enable), 32'h000000C3);
        @(posedge clock);
        alt_drain_disable <= 8'h81;
        @(negedge clock);
        check("drain alt", 32'(pad_control.drain_enable), 32'h00000024);
        sub_write(8'h03, 8'h00);
        @(negedge clock);
        check("drain zero", 32'(pad_control.drain_enable), 32'h0000007E);
        sub_write(8'h03, 8'hFF);
        @(posedge clock);
        alt_drain_disable <= 8'h00;
        @(negedge clock);
        check("drain all off", 32'(pad_control.drain_enable), 32'h0);
        sub_write(8'h04, 8'h00);
        sub_write(8'h06, 8'h00);
        @(negedge clock);
        check("pads off", 32'(pad_control), 32'h00000000);
    endtask

    task automatic wake_count(input logic [7:0] lv);
        @(posedge clock);
        pin_level <= lv;
        cnt = 0;
        repeat (10) begin
            @(negedge clock);
            if (stop_recovery === 1'b1)
                cnt++;
        end
    endtask

    task automatic test_wake();
        @(posedge clock);
        stop_state <= 1'b1;
        wake_count(8'h01);
        check("wake enabled pin", 32'(cnt), 32'h1);
        wake_count(8'h03);
        check("wake disabled pin", 32'(cnt), 32'h0);
        wake_count(8'h02);
        check("wake fall", 32'(cnt), 32'h1);
        @(posedge clock);
        stop_state <= 1'b0;
        wake_count(8'h03);
        check("wake outside stop", 32'(cnt), 32'h0);
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        print_verdict();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        reset_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 14'h0000;
        byteenable = 4'h0;
        writedata = 32'h00000000;
        alt_drain_disable = 8'h00;
        pin_level = 8'h00;
        stop_state = 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        test_reset();
        test_select();
        test_pads();
        test_wake();
        print_verdict();
    end
endmodule
